// [pfh_pkg.sv]
// shared constants, types and helpers of the fifo packet data handler
package pfh_pkg;

    // fifo storage and byte layout
    localparam int unsigned PFH_RAM_DEPTH  = 64;
    localparam int unsigned PFH_BYTE_W     = 8;
    localparam logic [2:0]  PFH_LAST_BIT   = 3'h7;
    localparam logic [6:0]  PFH_DEPTH_STEP = 7'h10;

    // framing values
    localparam logic [7:0]  PFH_PREAMBLE_BYTE = 8'haa;
    localparam logic [15:0] PFH_CRC_INIT      = 16'hffff;
    localparam logic [15:0] PFH_CRC_POLY      = 16'h1021;
    localparam logic [8:0]  PFH_WHITE_SEED    = 9'h1ff;

    // interrupt selector codes for receive and standby
    localparam logic [1:0] PFH_SEL0_WRBYTE = 2'h1;
    localparam logic [1:0] PFH_SEL0_NEMPTY = 2'h2;
    localparam logic [1:0] PFH_SEL0_SYNC   = 2'h3;
    localparam logic [1:0] PFH_SEL1_FULL   = 2'h1;
    localparam logic [1:0] PFH_SEL1_RSSI   = 2'h2;
    localparam logic [1:0] PFH_SEL1_THRESH = 2'h3;

    // chip operating modes
    typedef enum logic [3:0] {
        PFH_SLEEP = 4'h1,
        PFH_STBY  = 4'h2,
        PFH_RX    = 4'h4,
        PFH_TX    = 4'h8
    } pfh_mode_t;

    // packet transmit sequencer: source of the next byte loaded
    typedef enum logic [5:0] {
        PFH_T_FILL = 6'h01,
        PFH_T_PRE  = 6'h02,
        PFH_T_SYNC = 6'h04,
        PFH_T_PAY  = 6'h08,
        PFH_T_CRC  = 6'h10,
        PFH_T_DONE = 6'h20
    } pfh_tx_state_t;

    // static configuration
    typedef struct packed {
        logic        packet;      // 1 packet mode, 0 buffered mode
        logic [1:0]  fifo_size;   // depth 16 * (code + 1)
        logic [5:0]  fifo_thresh;
        logic [1:0]  irq0_sel;
        logic [1:0]  irq1_sel;
        logic        tx_irq1;
        logic        tx_start;
        logic        fill_method; // 1 host fill bit, 0 sync detection
        logic        fill;
        logic        sync_on;
        logic        pkt_var;
        logic [7:0]  payload_len;
        logic        crc_on;
        logic        manch_on;
        logic        white_on;
        logic        stby_access;
        logic [2:0]  preamble_len; // extra programmed preamble bytes
        logic [1:0]  sync_size;    // sync bytes minus one
        logic [31:0] sync_value;
    } pfh_cfg_t;

    // one byte through the ccitt checksum, msb first
    function automatic logic [15:0] pfh_crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ d[i]) ? ((r << 1) ^ PFH_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

endpackage

// [pfh_buf2.sv]
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module pfh_buf2
    import pfh_pkg::*;
(
    // clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  sys_rst_i,
    // fill side
    input  wire logic                  in_valid_i,
    input  wire logic [PFH_BYTE_W-1:0] in_data_i,
    output logic                       in_ready_o,
    // drain side
    output logic                       out_valid_o,
    output logic [PFH_BYTE_W-1:0]      out_data_o,
    input  wire logic                  out_ready_i
);
    logic                  v0, v1, next_v0, next_v1;
    logic [PFH_BYTE_W-1:0] d0, d1, next_d0, next_d1;

    assign in_ready_o  = ~v1;
    assign out_valid_o = v0;
    assign out_data_o  = d0;

    // shift out on drain, then place new word in first free slot
    always_comb begin
        next_v0 = v0;
        next_v1 = v1;
        next_d0 = d0;
        next_d1 = d1;
        if (v0 && out_ready_i) begin
            next_v0 = v1;
            next_d0 = d1;
            next_v1 = 1'b0;
        end
        if (in_valid_i && !v1) begin
            if (!next_v0) begin
                next_v0 = 1'b1;
                next_d0 = in_data_i;
            end else begin
                next_v1 = 1'b1;
                next_d1 = in_data_i;
            end
        end
    end

    // register stage
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            v0 <= 1'b0;
            v1 <= 1'b0;
            d0 <= '0;
            d1 <= '0;
        end else begin
            v0 <= next_v0;
            v1 <= next_v1;
            d0 <= next_d0;
            d1 <= next_d1;
        end
    end
endmodule
`default_nettype wire

// [pfh_core.sv]
// fifo packet data handler: fifo, bit shifters, framer and interrupt mapping
`timescale 1ns/100ps
`default_nettype none
module pfh_core
    import pfh_pkg::*;
(
    // clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  sys_rst_i,
    // configuration and mode
    input  wire pfh_cfg_t              cfg_i,
    input  wire pfh_mode_t             mode_i,
    input  wire logic                  overrun_clr_i,
    // host write port into the fifo
    input  wire logic                  wr_valid_i,
    input  wire logic [PFH_BYTE_W-1:0] wr_data_i,
    output logic                       wr_ready_o,
    // host read port out of the fifo
    output logic                       rd_valid_o,
    output logic [PFH_BYTE_W-1:0]      rd_data_o,
    input  wire logic                  rd_ready_i,
    // link pins from the modem
    input  wire logic                  link_bclk_i,
    input  wire logic                  link_rx_data_i,
    input  wire logic                  link_sync_i,
    input  wire logic                  link_rssi_i,
    // outputs
    output logic                       tx_data_o,
    output logic                       irq0_o,
    output logic                       irq1_o,
    output logic                       overrun_o,
    output logic                       tx_done_o,
    output logic                       bitsync_en_o,
    output logic                       sync_rec_en_o
);
    // fifo storage and pointers
    logic [PFH_BYTE_W-1:0] mem [PFH_RAM_DEPTH];
    logic [5:0]            wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [6:0]            count, next_count, depth;
    logic                  next_wr_ready;
    // link synchronisers
    logic [3:0]            meta, sync;
    logic                  bclk_prev, tick;
    // transmit state
    pfh_tx_state_t         tx_state, next_tx_state;
    logic [7:0]            sh_tx, next_sh_tx;
    logic [2:0]            tx_bit, next_tx_bit;
    logic                  phase, next_phase, coded, next_coded;
    logic [8:0]            lfsr, next_lfsr;
    logic [15:0]           crc, next_crc;
    logic [2:0]            pre_cnt, next_pre_cnt;
    logic [1:0]            sync_idx, next_sync_idx;
    logic [6:0]            pay_left, next_pay_left;
    logic                  first_pay, next_first_pay;
    logic                  started, next_started, busy, next_busy;
    logic                  next_tx_done, next_tx_data;
    // receive state
    logic [7:0]            sh_rx, next_sh_rx;
    logic [2:0]            rx_bit, next_rx_bit;
    logic                  sync_seen, next_sync_seen, next_overrun, wbyte, next_wbyte;
    // misc
    pfh_mode_t             prev_mode;
    logic                  next_irq0, next_irq1;
    // combinational helpers
    logic                  push, pop, buf_ready, feed;
    logic [7:0]            push_data, fifo_q, b_raw;
    logic                  not_empty, full, at_thresh, start_cond;
    logic                  host_rd_ok, host_wr_ok, wr_take, mch, adv;
    logic [6:0]            len_want;

    // fifo depth selection and flags
    assign depth      = 7'((7'(cfg_i.fifo_size) + 7'h1) * PFH_DEPTH_STEP);
    assign fifo_q     = mem[rd_ptr];
    assign not_empty  = (count != 7'h0);
    assign full       = (count >= depth);
    assign at_thresh  = (count >= 7'(cfg_i.fifo_thresh));
    assign host_rd_ok = (mode_i == PFH_RX) ||
                        ((mode_i == PFH_STBY) && (!cfg_i.packet || cfg_i.stby_access));
    assign host_wr_ok = (mode_i == PFH_TX) ||
                        ((mode_i == PFH_STBY) && cfg_i.packet && cfg_i.stby_access);
    assign wr_take    = wr_valid_i && wr_ready_o && host_wr_ok;
    assign feed       = host_rd_ok && not_empty && buf_ready;
    assign tick       = sync[0] && !bclk_prev;

    // start condition: first byte, or threshold (packet) / full (buffered)
    assign start_cond = cfg_i.tx_start ? not_empty :
                        (cfg_i.packet ? at_thresh : full);

    // link inputs pass two flip-flops
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            meta      <= 4'h0;
            sync      <= 4'h0;
            bclk_prev <= 1'b0;
        end else begin
            meta      <= {link_rssi_i, link_sync_i, link_rx_data_i, link_bclk_i};
            sync      <= meta;
            bclk_prev <= sync[0];
        end
    end

    // host read path through the two-entry buffer
    pfh_buf2 u_rdbuf (
        .core_clk_i  (core_clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (feed),
        .in_data_i   (fifo_q),
        .in_ready_o  (buf_ready),
        .out_valid_o (rd_valid_o),
        .out_data_o  (rd_data_o),
        .out_ready_i (rd_ready_i)
    );

    // next-state of transmit, receive, fifo and interrupts
    always_comb begin
        next_tx_state  = tx_state;
        next_sh_tx     = sh_tx;
        next_tx_bit    = tx_bit;
        next_phase     = phase;
        next_coded     = coded;
        next_lfsr      = lfsr;
        next_crc       = crc;
        next_pre_cnt   = pre_cnt;
        next_sync_idx  = sync_idx;
        next_pay_left  = pay_left;
        next_first_pay = first_pay;
        next_started   = started;
        next_busy      = busy;
        next_tx_done   = tx_done_o;
        next_tx_data   = 1'b0;
        next_sh_rx     = sh_rx;
        next_rx_bit    = rx_bit;
        next_sync_seen = sync_seen;
        next_overrun   = overrun_o && !overrun_clr_i;
        next_wbyte     = 1'b0;
        push           = wr_take;
        push_data      = wr_data_i;
        pop            = feed;
        mch            = 1'b0;
        adv            = 1'b0;
        b_raw          = 8'h0;
        len_want       = 7'h0;
        // transmit
        if (mode_i != PFH_TX) begin
            next_tx_done = 1'b0;   // transmitter stops at once outside transmit
            next_busy    = 1'b0;
            next_started = 1'b0;
        end else if (prev_mode != PFH_TX) begin
            next_tx_state = PFH_T_FILL;
            next_sh_tx    = PFH_PREAMBLE_BYTE;
            next_tx_bit   = 3'h0;
            next_phase    = 1'b0;
            next_coded    = 1'b0;
            next_tx_done  = 1'b0;
            next_started  = cfg_i.packet && cfg_i.stby_access && start_cond;
        end else begin
            if (!(cfg_i.packet && cfg_i.stby_access) && start_cond && !tx_done_o) begin
                next_started = 1'b1;
            end
            next_tx_data = tx_data_o;
            if (tick) begin
                b_raw[0]     = sh_tx[7] ^ (coded && cfg_i.white_on && lfsr[0]);
                mch          = coded && cfg_i.manch_on;
                next_tx_data = (cfg_i.packet || busy) ? (b_raw[0] ^ (mch && phase)) : 1'b0;
                adv          = !mch || phase;
                next_phase   = mch && !phase;
            end
            if (adv) begin
                next_sh_tx  = {sh_tx[6:0], 1'b0};
                next_tx_bit = 3'(tx_bit + 3'h1);
                if (coded && cfg_i.white_on) begin
                    next_lfsr = {lfsr[0] ^ lfsr[5], lfsr[8:1]};
                end
            end
            // byte boundary: load the next byte into the shifter
            if (adv && tx_bit == PFH_LAST_BIT) begin
                if (!cfg_i.packet) begin
                    if (started && not_empty && !pop) begin
                        pop        = 1'b1;
                        next_sh_tx = fifo_q;
                        next_busy  = 1'b1;
                    end else begin
                        next_tx_done = tx_done_o || busy;
                        next_busy    = 1'b0;
                    end
                end else begin
                    next_coded = 1'b0;
                    next_sh_tx = PFH_PREAMBLE_BYTE;
                    case (tx_state)
                        PFH_T_FILL: begin
                            if (started) begin
                                next_tx_state = PFH_T_PRE;
                                next_pre_cnt  = cfg_i.preamble_len;
                            end
                        end
                        PFH_T_PRE, PFH_T_SYNC: begin
                            if (tx_state == PFH_T_PRE && pre_cnt != 3'h0) begin
                                next_pre_cnt = 3'(pre_cnt - 3'h1);
                            end else begin
                                next_sh_tx    = cfg_i.sync_value[8*(3-sync_idx) +: 8];
                                next_sync_idx = 2'(sync_idx + 2'h1);
                                next_tx_state = PFH_T_SYNC;
                                if (sync_idx == cfg_i.sync_size) begin
                                    next_tx_state  = PFH_T_PAY;
                                    next_sync_idx  = 2'h0;
                                    next_first_pay = 1'b1;
                                    next_crc       = PFH_CRC_INIT;
                                    next_lfsr      = PFH_WHITE_SEED;
                                end
                            end
                        end
                        PFH_T_PAY: begin
                            next_coded     = 1'b1;
                            next_sh_tx     = not_empty ? fifo_q : 8'h0;
                            pop            = not_empty && !pop;
                            next_crc       = pfh_crc_byte(crc, next_sh_tx);
                            next_first_pay = 1'b0;
                            if (first_pay) begin
                                len_want = cfg_i.pkt_var ? 7'(next_sh_tx) :
                                    ((cfg_i.payload_len == 8'h0) ? 7'h0 :
                                     7'(cfg_i.payload_len - 8'h1));
                                next_pay_left = (len_want >= depth) ?
                                    7'(depth - 7'h1) : len_want;
                            end else begin
                                next_pay_left = 7'(pay_left - 7'h1);
                            end
                            if (next_pay_left == 7'h0) begin
                                next_tx_state = cfg_i.crc_on ? PFH_T_CRC : PFH_T_DONE;
                            end
                        end
                        PFH_T_CRC: begin
                            next_coded    = 1'b1;
                            next_sh_tx    = sync_idx[0] ? crc[7:0] : crc[15:8];
                            next_sync_idx = sync_idx[0] ? 2'h0 : 2'h1;
                            if (sync_idx[0]) begin
                                next_tx_state = PFH_T_DONE;
                            end
                        end
                        default: begin
                            next_tx_done  = 1'b1;
                            next_started  = 1'b0;
                            next_tx_state = PFH_T_FILL;
                        end
                    endcase
                end
            end
        end
        // buffered receive; partial byte dropped outside receive
        if (mode_i != PFH_RX) begin
            next_rx_bit    = 3'h0;
            next_sync_seen = 1'b0;
        end else begin
            if (sync[2] && (cfg_i.sync_on || cfg_i.packet)) begin
                next_sync_seen = 1'b1;
            end
            if (!cfg_i.packet && tick && (cfg_i.fill_method ? cfg_i.fill : sync_seen)) begin
                next_sh_rx  = {sh_rx[6:0], sync[1]};
                next_rx_bit = 3'(rx_bit + 3'h1);
                if (rx_bit == PFH_LAST_BIT) begin
                    if (full) begin
                        next_overrun = 1'b1;
                    end else begin
                        push       = 1'b1;
                        push_data  = next_sh_rx;
                        next_wbyte = 1'b1;
                    end
                end
            end
        end
        // fifo pointers
        next_wr_ptr   = push ? 6'(wr_ptr + 6'h1) : wr_ptr;
        next_rd_ptr   = pop ? 6'(rd_ptr + 6'h1) : rd_ptr;
        next_count    = 7'(count + 7'(push) - 7'(pop));
        next_wr_ready = (next_count < depth);
        // interrupt mapping as levels
        next_irq0 = 1'b0;
        next_irq1 = 1'b0;
        case (mode_i)
            PFH_TX: begin
                next_irq0 = not_empty;
                next_irq1 = cfg_i.tx_irq1 ? tx_done_o : full;
            end
            PFH_RX: begin
                case (cfg_i.irq0_sel)
                    PFH_SEL0_WRBYTE: next_irq0 = wbyte;
                    PFH_SEL0_NEMPTY: next_irq0 = not_empty;
                    PFH_SEL0_SYNC:   next_irq0 = sync_seen;
                    default:         next_irq0 = 1'b0;
                endcase
                case (cfg_i.irq1_sel)
                    PFH_SEL1_FULL:   next_irq1 = full;
                    PFH_SEL1_RSSI:   next_irq1 = sync[3];
                    PFH_SEL1_THRESH: next_irq1 = at_thresh;
                    default:         next_irq1 = 1'b0;
                endcase
            end
            PFH_STBY: begin
                next_irq0 = (cfg_i.irq0_sel == PFH_SEL0_NEMPTY) && not_empty;
                next_irq1 = ((cfg_i.irq1_sel == PFH_SEL1_FULL) && full) ||
                            ((cfg_i.irq1_sel == PFH_SEL1_THRESH) && at_thresh);
            end
            default: begin
                next_irq0 = 1'b0;
                next_irq1 = 1'b0;
            end
        endcase
    end

    // fifo storage write
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= push_data;
        end
    end

    // register stage
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            wr_ptr <= 6'h0;           rd_ptr <= 6'h0;           count <= 7'h0;
            wr_ready_o <= 1'b0;       tx_state <= PFH_T_FILL;   sh_tx <= 8'h0;
            tx_bit <= 3'h0;           phase <= 1'b0;            coded <= 1'b0;
            lfsr <= PFH_WHITE_SEED;   crc <= PFH_CRC_INIT;      pre_cnt <= 3'h0;
            sync_idx <= 2'h0;         pay_left <= 7'h0;         first_pay <= 1'b0;
            started <= 1'b0;          busy <= 1'b0;             tx_done_o <= 1'b0;
            tx_data_o <= 1'b0;        sh_rx <= 8'h0;            rx_bit <= 3'h0;
            sync_seen <= 1'b0;        overrun_o <= 1'b0;        wbyte <= 1'b0;
            prev_mode <= PFH_SLEEP;   irq0_o <= 1'b0;           irq1_o <= 1'b0;
            bitsync_en_o <= 1'b0;     sync_rec_en_o <= 1'b0;
        end else begin
            wr_ptr <= next_wr_ptr;    rd_ptr <= next_rd_ptr;    count <= next_count;
            wr_ready_o <= next_wr_ready;
            tx_state <= next_tx_state; sh_tx <= next_sh_tx;     tx_bit <= next_tx_bit;
            phase <= next_phase;      coded <= next_coded;      lfsr <= next_lfsr;
            crc <= next_crc;          pre_cnt <= next_pre_cnt;  sync_idx <= next_sync_idx;
            pay_left <= next_pay_left; first_pay <= next_first_pay;
            started <= next_started;  busy <= next_busy;        tx_done_o <= next_tx_done;
            tx_data_o <= next_tx_data; sh_rx <= next_sh_rx;     rx_bit <= next_rx_bit;
            sync_seen <= next_sync_seen; overrun_o <= next_overrun; wbyte <= next_wbyte;
            prev_mode <= mode_i;      irq0_o <= next_irq0;      irq1_o <= next_irq1;
            bitsync_en_o <= 1'b1;
            sync_rec_en_o <= cfg_i.packet || cfg_i.sync_on;
        end
    end
endmodule
`default_nettype wire

// [pfh_asserts.sv]
// port checker of the fifo packet data handler
`timescale 1ns/100ps
`default_nettype none
module pfh_asserts
    import pfh_pkg::*;
(
    // clock, reset and inputs
    input wire logic      core_clk_i,
    input wire logic      sys_rst_i,
    input wire pfh_cfg_t  cfg_i,
    input wire pfh_mode_t mode_i,
    input wire logic      overrun_clr_i,
    input wire logic      link_sync_i,
    input wire logic      link_rssi_i,
    // outputs watched
    input wire logic      irq0_o,
    input wire logic      irq1_o,
    input wire logic      overrun_o,
    input wire logic      tx_done_o,
    input wire logic      bitsync_en_o,
    input wire logic      sync_rec_en_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    // a source held high under its selector in receive
    sequence s_sync_held;
        (mode_i == PFH_RX && cfg_i.irq0_sel == PFH_SEL0_SYNC && link_sync_i
            && (cfg_i.sync_on || cfg_i.packet)) [*6];
    endsequence
    sequence s_rssi_held;
        (mode_i == PFH_RX && cfg_i.irq1_sel == PFH_SEL1_RSSI && link_rssi_i) [*6];
    endsequence
    sync_irq_a: assert property (s_sync_held |-> irq0_o)
        else $error("irq0 misses sync");
    rssi_irq_a: assert property (s_rssi_held |-> irq1_o)
        else $error("irq1 misses rssi");
    sel_zero_a: assert property ((mode_i == PFH_RX && cfg_i.irq0_sel == 2'h0
        && cfg_i.irq1_sel == 2'h0) [*2] |-> !irq0_o && !irq1_o)
        else $error("unselected irq high");
    done_irq_a: assert property (mode_i == PFH_TX && cfg_i.tx_irq1
        |=> irq1_o == $past(tx_done_o)) else $error("irq1 not following done");
    pkt_sync_a: assert property (cfg_i.packet |=> sync_rec_en_o && bitsync_en_o)
        else $error("packet mode without sync enables");
    ovr_hold_a: assert property (overrun_o && !overrun_clr_i |=> overrun_o)
        else $error("overrun lost");
    ovr_clr_a: assert property (overrun_clr_i && mode_i != PFH_RX |=> !overrun_o)
        else $error("overrun not cleared");
    done_hold_a: assert property (tx_done_o && mode_i == PFH_TX |=> tx_done_o)
        else $error("done dropped in transmit");
    done_clr_a: assert property ((mode_i != PFH_TX) [*2] |-> !tx_done_o)
        else $error("done outside transmit");
endmodule
`default_nettype wire

// [pfh_link_model.sv]
// modem side model: free bit clock and a random steady receive level
`timescale 1ns/100ps
`default_nettype none
module pfh_link_model (
    // bit stream to the block
    output logic link_bclk_o,
    output logic link_rx_data_o
);
    // 160 ns bit clock off the core phase; receive level held, so each byte is all ones or zeros
    initial begin
        link_bclk_o = 1'b0;
        link_rx_data_o = 1'($urandom);
        #7;
        forever begin
            #80 link_bclk_o = ~link_bclk_o;
        end
    end
endmodule
`default_nettype wire

// [tb_pfh_core.sv]
// self-checking bench of the fifo packet data handler
`timescale 1ns/100ps
`default_nettype none
module tb_pfh_core
    import pfh_pkg::*;
;
    logic        clk = 1'b0, rst = 1'b1, clr = 1'b0, wr_v = 1'b0, rd_r = 1'b0;
    logic        sync_p = 1'b0, rssi_p = 1'b0, bq = 1'b0, dq = 1'b0;
    logic        wr_r, rd_v, txd, irq0, irq1, ovr, done, bclk, rxd;
    logic [7:0]  wr_d = 8'h0, rd_d, d, s;
    logic [15:0] c;
    logic [63:0] sh = '0;
    logic [63:0] exp_q[$];
    pfh_cfg_t    cfg = '0;
    pfh_mode_t   mode = PFH_SLEEP;
    int          fails = 0, total_checks = 0, cyc = 0, n;
    pfh_core i_pfh_core (.core_clk_i(clk), .sys_rst_i(rst), .cfg_i(cfg), .mode_i(mode),
        .overrun_clr_i(clr), .wr_valid_i(wr_v), .wr_data_i(wr_d), .wr_ready_o(wr_r),
        .rd_valid_o(rd_v), .rd_data_o(rd_d), .rd_ready_i(rd_r), .link_bclk_i(bclk),
        .link_rx_data_i(rxd), .link_sync_i(sync_p), .link_rssi_i(rssi_p), .tx_data_o(txd),
        .irq0_o(irq0), .irq1_o(irq1), .overrun_o(ovr), .tx_done_o(done),
        .bitsync_en_o(), .sync_rec_en_o());
    pfh_link_model i_pfh_link_model (.link_bclk_o(bclk), .link_rx_data_o(rxd));
    task automatic chk(input logic [63:0] seen, input logic [63:0] want);
        total_checks++;
        if (seen !== want) begin
            fails++;
            $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [15:0] crc_add(input logic [15:0] r, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? PFH_CRC_POLY : 16'h0);
        return r;
    endfunction
    // write one byte, held until ready is seen at an edge
    task automatic wr(input logic [7:0] b);
        wr_v <= 1'b1;
        wr_d <= b;
        do @(posedge clk); while (wr_r !== 1'b1);
    endtask
    initial forever #10 clk = ~clk;
    // bit capture, frame compare at done, run ceiling
    always @(posedge clk) begin
        bq <= bclk;
        cyc <= cyc + 1;
        // sample each bit mid-period, on the link clock's fall, last bit included
        if (!bclk && bq) begin
            sh <= {sh[62:0], txd};
            dq <= done;
            if (done && !dq && exp_q.size() > 0)
                chk({sh[62:0], txd}, exp_q.pop_front());
        end
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        void'($urandom(86894));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        mode <= PFH_RX;
        repeat (3) @(posedge clk);
        chk(irq0 | irq1, 1'b0);
        // buffered receive: sync and rssi sources, then overrun with host stalled
        cfg.fill_method <= 1'b1;
        cfg.fill <= 1'b1;
        cfg.sync_on <= 1'b1;
        cfg.irq0_sel <= PFH_SEL0_SYNC;
        cfg.irq1_sel <= PFH_SEL1_RSSI;
        mode <= PFH_RX;
        sync_p <= 1'b1;
        rssi_p <= 1'b1;
        repeat (10) @(posedge clk);
        chk(irq0, 1'b1);
        chk(irq1, 1'b1);
        sync_p <= 1'b0;
        cfg.irq0_sel <= PFH_SEL0_NEMPTY;
        cfg.irq1_sel <= PFH_SEL1_FULL;
        for (n = 0; ovr !== 1'b1 && n < 3000; n++) @(posedge clk);
        chk(ovr, 1'b1);
        chk(irq1, 1'b1);
        clr <= 1'b1;
        mode <= PFH_STBY;
        repeat (2) @(posedge clk);
        clr <= 1'b0;
        rd_r <= 1'b1;
        n = 0;
        repeat (80) @(posedge clk) if (rd_v === 1'b1) begin
            n++;
            chk(rd_d, {8{rxd}});
        end
        chk(n >= 16 && n <= 18, 1'b1);
        chk(irq0, 1'b0);
        rd_r <= 1'b0;
        // packet transmit: fixed at first byte, variable at threshold, then buffered
        for (int k = 0; k < 3; k++) begin
            s = 8'($urandom);
            d = 8'($urandom);
            cfg <= '0;
            cfg.packet <= (k < 2);
            cfg.crc_on <= 1'b1;
            cfg.tx_irq1 <= 1'b1;
            cfg.payload_len <= 8'h1;
            cfg.sync_value <= {4{s}};
            cfg.pkt_var <= k[0];
            cfg.tx_start <= !k[0];
            cfg.fifo_thresh <= 6'h2;
            mode <= PFH_TX;
            repeat ((k == 2) ? 500 : 300) @(posedge clk);
            c = crc_add(PFH_CRC_INIT, k ? 8'h01 : d);
            if (k) c = crc_add(c, d);
            exp_q.push_back((k == 2) ? {56'h0, d} : k ? {24'haaaaaa, s, 8'h01, d, c} :
                {32'haaaaaaaa, s, d, c});
            if (k == 1) wr(8'h01);
            wr(d);
            wr_v <= 1'b0;
            for (n = 0; done !== 1'b1 && n < 3000; n++) @(posedge clk);
            chk(done, 1'b1);
            repeat (20) @(posedge clk);
            mode <= PFH_STBY;
            repeat (20) @(posedge clk);
        end
        chk(exp_q.size(), 0);
        finish_test();
    end
endmodule
bind pfh_core pfh_asserts i_pfh_asserts (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .cfg_i(cfg_i), .mode_i(mode_i), .overrun_clr_i(overrun_clr_i), .link_sync_i(link_sync_i),
    .link_rssi_i(link_rssi_i), .irq0_o(irq0_o), .irq1_o(irq1_o), .overrun_o(overrun_o),
    .tx_done_o(tx_done_o), .bitsync_en_o(bitsync_en_o), .sync_rec_en_o(sync_rec_en_o));
`default_nettype wire
